// *** verilog/dmsc_pkg.sv ***
// package: register map, field layouts and states of the serial channel
package dmsc_pkg;

	// ------------------------------------------------------------
	// register map and reset values
	// ------------------------------------------------------------
	localparam logic [15:0] ADDR_DATA = 16'hff70;
	localparam logic [15:0] ADDR_AMC  = 16'hff71;
	localparam logic [15:0] ADDR_AES  = 16'hff72;
	localparam logic [15:0] ADDR_RGC  = 16'hff73;
	localparam logic [15:0] ADDR_CMC  = 16'hff74;
	localparam logic [7:0]  HOLD_RST  = 8'hff;
	localparam logic [7:0]  CTRL_RST  = 8'h00;
	localparam logic [1:0]  SYNC_RST  = 2'h3;

	// ------------------------------------------------------------
	// rate generator
	// ------------------------------------------------------------
	localparam logic [3:0]  DIV_PASS   = 4'hf;
	localparam logic [4:0]  DIV_BASE   = 5'h0f;
	localparam logic [3:0]  PRE_N11    = 4'h0;
	localparam logic [3:0]  PRE_FIRST  = 4'h5;
	localparam logic [3:0]  PRE_LAST   = 4'he;
	localparam int          PRE_W      = 10;
	localparam logic [9:0]  PRE_N11_TC = 10'h3ff;

	// ------------------------------------------------------------
	// frame
	// ------------------------------------------------------------
	localparam logic [3:0]  BITS_8    = 4'h8;
	localparam logic [3:0]  BITS_7    = 4'h7;
	localparam logic [1:0]  PAR_NONE  = 2'h0;
	localparam logic [1:0]  PAR_ZERO  = 2'h1;
	localparam logic [1:0]  PAR_ODD   = 2'h2;
	localparam logic [1:0]  PAR_EVEN  = 2'h3;
	localparam int          DATA_W    = 8;
	localparam int          TXQ_DEPTH = 4;

	// ------------------------------------------------------------
	// carriers
	// ------------------------------------------------------------
	typedef struct packed {
		logic       tx_en;
		logic       rx_en;
		logic [1:0] parity;
		logic       len8;
		logic       stop2;
		logic       rsv;
		logic       int_src;
	} dmsc_amc_t;

	typedef struct packed {
		logic       en;
		logic [3:0] rsv;
		logic       lsb_first;
		logic       int_clk;
		logic       rsv0;
	} dmsc_cmc_t;

	typedef struct packed {
		logic [4:0] rsv;
		logic       par_err;
		logic       frm_err;
		logic       ovr_err;
	} dmsc_aes_t;

	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [15:0] addr;
		logic [7:0]  wdata;
	} dmsc_sfr_req_t;

	typedef enum logic [5:0] {
		TX_IDLE  = 6'h01,
		TX_START = 6'h02,
		TX_DATA  = 6'h04,
		TX_PAR   = 6'h08,
		TX_STOP  = 6'h10,
		TX_SYNC  = 6'h20
	} dmsc_tx_st_t;

	typedef enum logic [4:0] {
		RX_IDLE  = 5'h01,
		RX_START = 5'h02,
		RX_DATA  = 5'h04,
		RX_PAR   = 5'h08,
		RX_STOP  = 5'h10
	} dmsc_rx_st_t;

endpackage

// *** verilog/dmsc_fifo.sv ***
// transmit queue between the register port and the transmitter
`timescale 1ns/1ns
module dmsc_fifo #(
	parameter int W     = 8,
	parameter int DEPTH = 4
) (
	input  logic         clk,
	input  logic         rstn,
	input  logic         in_valid,
	output logic         in_ready,
	input  logic [W-1:0] in_data,
	output logic         out_valid,
	input  logic         out_ready,
	output logic [W-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	logic [W-1:0] mem_ff [DEPTH];
	logic [AW-1:0] wp_ff;
	logic [AW-1:0] rp_ff;
	logic [AW:0]   cnt_ff;
	logic          push;
	logic          pop;

	assign in_ready  = cnt_ff != (AW+1)'(DEPTH);
	assign out_valid = cnt_ff != '0;
	assign out_data  = mem_ff[rp_ff];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			for (int i = 0; i < DEPTH; i++) begin
				mem_ff[i] <= '0;
			end
		end else if (push) begin
			mem_ff[wp_ff] <= in_data;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			wp_ff  <= '0;
			rp_ff  <= '0;
			cnt_ff <= '0;
		end else begin
			if (push)
				wp_ff <= (wp_ff == AW'(DEPTH-1)) ? '0 : wp_ff + 1'b1;
			if (pop)
				rp_ff <= (rp_ff == AW'(DEPTH-1)) ? '0 : rp_ff + 1'b1;
			cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule

// *** verilog/dmsc_rate_gen.sv ***
// prescaler and 5-bit divider producing half-bit ticks
`timescale 1ns/1ns
module dmsc_rate_gen
	import dmsc_pkg::*;
(
	input  logic       clk,
	input  logic       rstn,
	input  logic       restart,
	input  logic [3:0] pre_sel,
	input  logic [3:0] div_sel,
	input  logic       use_ext,
	input  logic       ext_edge,
	output logic       half_tick_ff
);
	// {legal, terminal count}; half-bit source runs at clk / 2^(n-1)
	function automatic logic [10:0] pre_tc(input logic [3:0] code);
		logic [10:0] r;
		r = 11'h000;
		if (code == PRE_N11)
			r = {1'b1, PRE_N11_TC};
		else if (code >= PRE_FIRST && code <= PRE_LAST)
			r = {1'b1, 10'((10'h001 << (code - PRE_FIRST)) - 10'h001)};
		return r;
	endfunction

	logic [PRE_W-1:0] pre_ff;
	logic [4:0]       div_ff;
	logic [10:0]      pre;
	logic             src_tick;
	logic [4:0]       div_tc;

	assign pre      = pre_tc(pre_sel);
	// external source: one rising pin edge per count, bit = 2*(k+16) edges
	assign src_tick = use_ext ? ext_edge : (pre[10] && pre_ff == pre[9:0]);
	assign div_tc   = (div_sel == DIV_PASS) ? 5'h00 :
		DIV_BASE + {1'b0, div_sel};

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			pre_ff <= '0;
		else if (restart || use_ext || src_tick)
			pre_ff <= '0;
		else
			pre_ff <= pre_ff + 10'h001;
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			div_ff <= 5'h00;
		else if (restart)
			div_ff <= 5'h00;
		else if (src_tick)
			div_ff <= (div_ff == div_tc) ? 5'h00 : div_ff + 5'h01;
	end

	// two half ticks make one bit: clk / (2^n * (k+16))
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			half_tick_ff <= 1'b0;
		else
			half_tick_ff <= !restart && src_tick && div_ff == div_tc;
	end
endmodule

// *** verilog/dmsc_channel.sv ***
// serial channel: stop, asynchronous and three-wire clocked modes
//
// Summary of operation
// - a write to the transmit holding register queues the byte unless four wait; transmission starts once the transmitter is idle and enabled.
// - seven-bit length sends only bits 0 to 6 of the written byte.
// - seven-bit receive fills bits 0 to 6, top bit reads zero.
// - transmit and receive holding share one address; read rx, write tx.
// - both holding registers reset to all ones.
// - each finished character is copied from shifter into receive holding, except on async overrun; three-wire always copies.
// - async transmit adds start, optional parity and stop bits.
// - receiver checks errors and records their type in the status register.
// - overrun repeats on each character until receive holding is read.
// - with two stop bits selected only the first is checked.
// - status register content is undefined in three-wire mode.
// - divider field divides the prescaled clock by 16 plus k.
// - divider all ones passes clock undivided; three-wire mode only, though async mode also gets the undivided clock.
// - three-wire mode uses only internal clock, driven out on clock pin.
// - three-wire shifts 8 bits both ways at once, msb or lsb first.
// - async mode moves one byte per start bit, full duplex.
// - async clock source bit set selects internal generator, frees pin.
// - internal async rate is clock over 2^n times (k plus 16).
// - external async rate is pin frequency over 2 times (k plus 16).
`timescale 1ns/1ns
module dmsc_channel
	import dmsc_pkg::*;
(
	input  logic          clk,
	input  logic          rstn,
	input  dmsc_sfr_req_t sfr_req,
	output logic [7:0]    sfr_rdata_ff,
	input  logic          data_in_pin,
	input  logic          rate_clk_pin,
	output logic          data_out_ff,
	output logic          data_out_en_n_ff,
	output logic          sclk_out_ff,
	output logic          sclk_out_en_n_ff,
	output logic          tx_queue_full_ff,
	output logic          tx_done_ff,
	output logic          rx_done_ff,
	output logic          rx_error_ff
);

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function automatic logic hit(input dmsc_sfr_req_t r,
		input logic [15:0] a);
		return r.addr == a;
	endfunction

	function automatic logic par_of(input logic [1:0] mode,
		input logic [7:0] d);
		logic p;
		p = 1'b0;
		if (mode == PAR_EVEN)
			p = ^d;
		else if (mode == PAR_ODD)
			p = ~^d;
		return p;
	endfunction

	// ------------------------------------------------------------
	// declarations
	// ------------------------------------------------------------
	logic [7:0]  rgc_ff;
	dmsc_amc_t   amc_ff;
	dmsc_cmc_t   cmc_ff;
	dmsc_aes_t   aes_ff;
	logic [7:0]  hold_tx_ff;
	logic [7:0]  hold_rx_ff;
	logic        rx_unread_ff;

	logic [1:0]  s1_ff;
	logic [1:0]  s2_ff;
	logic [1:0]  s3_ff;
	logic [1:0]  filt_ff;
	logic        rxd_prev_ff;
	logic        external_rate_clock_pin_prev_ff;
	logic        rxd;
	logic        external_rate_clock_pin;

	dmsc_tx_st_t tx_st_ff;
	logic [7:0]  tx_sh_ff;
	logic [3:0]  tx_cnt_ff;
	logic        tx_ph_ff;
	logic        tx_stop_ff;
	logic        tx_par_ff;
	logic [7:0]  sy_in_ff;
	logic        sy_done_ff;

	dmsc_rx_st_t rx_st_ff;
	logic [7:0]  rx_sh_ff;
	logic [3:0]  rx_cnt_ff;
	logic        rx_ph_ff;
	logic        rx_par_ff;
	logic        rx_fe_ff;
	logic        rx_commit_ff;

	logic        async_on;
	logic        sync_on;
	logic        use_ext;
	logic        ext_edge;
	logic [3:0]  last_bit;
	logic        wr_data;
	logic        rd_data;
	logic        q_in_ready;
	logic        q_valid;
	logic [7:0]  q_data;
	logic [7:0]  q_word;
	logic        pop;
	logic        tx_half;
	logic        tx_bit_end;
	logic        rx_half;
	logic        rx_smp;
	logic        rx_go;
	logic [7:0]  rx_word;
	logic        rx_pe;
	logic        unread_eff;

	// ------------------------------------------------------------
	// mode decode
	// ------------------------------------------------------------
	assign async_on = amc_ff.tx_en || amc_ff.rx_en;
	assign sync_on  = cmc_ff.en;
	// three-wire never takes the pin clock; async takes it unless
	// the internal source is chosen
	assign use_ext  = async_on && !sync_on && !amc_ff.int_src;
	assign ext_edge = external_rate_clock_pin && !external_rate_clock_pin_prev_ff;
	assign last_bit = (amc_ff.len8 ? BITS_8 : BITS_7) - 4'h1;

	assign wr_data = sfr_req.wr && hit(sfr_req, ADDR_DATA);
	assign rd_data = sfr_req.rd && hit(sfr_req, ADDR_DATA);

	// ------------------------------------------------------------
	// pin input synchronisers
	// ------------------------------------------------------------
	// a level change is taken once the second and third stages agree
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			s1_ff   <= SYNC_RST;
			s2_ff   <= SYNC_RST;
			s3_ff   <= SYNC_RST;
			filt_ff <= SYNC_RST;
		end else begin
			s1_ff   <= {rate_clk_pin, data_in_pin};
			s2_ff   <= s1_ff;
			s3_ff   <= s2_ff;
			filt_ff <= (s2_ff & s3_ff) | (filt_ff & (s2_ff ^ s3_ff));
		end
	end

	assign rxd  = filt_ff[0];
	assign external_rate_clock_pin = filt_ff[1];

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rxd_prev_ff  <= 1'b1;
			external_rate_clock_pin_prev_ff <= 1'b1;
		end else begin
			rxd_prev_ff  <= rxd;
			external_rate_clock_pin_prev_ff <= external_rate_clock_pin;
		end
	end

	// ------------------------------------------------------------
	// control registers
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rgc_ff <= CTRL_RST;
			amc_ff <= CTRL_RST;
			cmc_ff <= CTRL_RST;
		end else if (sfr_req.wr) begin
			if (hit(sfr_req, ADDR_RGC))
				rgc_ff <= sfr_req.wdata;
			if (hit(sfr_req, ADDR_AMC))
				amc_ff <= sfr_req.wdata;
			if (hit(sfr_req, ADDR_CMC))
				cmc_ff <= sfr_req.wdata;
		end
	end

	// ------------------------------------------------------------
	// transmit queue and rate generators
	// ------------------------------------------------------------
	// a write when four bytes wait is dropped; the full flag warns
	dmsc_fifo #(
		.W     (DATA_W),
		.DEPTH (TXQ_DEPTH)
	) u_txq (
		.clk       (clk),
		.rstn      (rstn),
		.in_valid  (wr_data),
		.in_ready  (q_in_ready),
		.in_data   (sfr_req.wdata),
		.out_valid (q_valid),
		.out_ready (pop),
		.out_data  (q_data)
	);

	assign pop = q_valid && tx_st_ff == TX_IDLE &&
		(amc_ff.tx_en || sync_on);

	// restarting on each start keeps the first bit a full bit long
	dmsc_rate_gen u_tx_rate (
		.clk          (clk),
		.rstn         (rstn),
		.restart      (pop),
		.pre_sel      (rgc_ff[7:4]),
		.div_sel      (rgc_ff[3:0]),
		.use_ext      (use_ext),
		.ext_edge     (ext_edge),
		.half_tick_ff (tx_half)
	);

	dmsc_rate_gen u_rx_rate (
		.clk          (clk),
		.rstn         (rstn),
		.restart      (rx_go),
		.pre_sel      (rgc_ff[7:4]),
		.div_sel      (rgc_ff[3:0]),
		.use_ext      (use_ext),
		.ext_edge     (ext_edge),
		.half_tick_ff (rx_half)
	);

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			hold_tx_ff <= HOLD_RST;
		else if (pop)
			hold_tx_ff <= q_data;
	end

	// ------------------------------------------------------------
	// transmitter and three-wire shifter
	// ------------------------------------------------------------
	assign q_word     = amc_ff.len8 ? q_data : {1'b0, q_data[6:0]};
	assign tx_bit_end = tx_half && tx_ph_ff;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			tx_st_ff    <= TX_IDLE;
			tx_sh_ff    <= HOLD_RST;
			tx_cnt_ff   <= 4'h0;
			tx_ph_ff    <= 1'b0;
			tx_stop_ff  <= 1'b0;
			tx_par_ff   <= 1'b0;
			data_out_ff <= 1'b1;
			sclk_out_ff <= 1'b1;
			tx_done_ff  <= 1'b0;
			sy_in_ff    <= HOLD_RST;
			sy_done_ff  <= 1'b0;
		end else begin
			tx_done_ff <= 1'b0;
			sy_done_ff <= 1'b0;
			tx_ph_ff   <= tx_ph_ff ^ tx_half;
			unique case (tx_st_ff)
			TX_IDLE: begin
				tx_ph_ff    <= 1'b0;
				data_out_ff <= 1'b1;
				sclk_out_ff <= 1'b1;
				tx_cnt_ff   <= 4'h0;
				tx_stop_ff  <= 1'b0;
				if (pop && sync_on) begin
					tx_st_ff <= TX_SYNC;
					tx_sh_ff <= q_data;
				end else if (pop) begin
					tx_st_ff    <= TX_START;
					tx_sh_ff    <= q_word;
					tx_par_ff   <= par_of(amc_ff.parity, q_word);
				end
			end
			TX_START: begin
				// line drops one cycle after the pop: the registered
				// half tick would otherwise stretch the start bit
				data_out_ff <= 1'b0;
				if (tx_bit_end) begin
					tx_st_ff    <= TX_DATA;
					data_out_ff <= tx_sh_ff[0];
					tx_sh_ff    <= {1'b0, tx_sh_ff[7:1]};
				end
			end
			TX_DATA: begin
				if (tx_bit_end) begin
					if (tx_cnt_ff == last_bit) begin
						if (amc_ff.parity != PAR_NONE) begin
							tx_st_ff    <= TX_PAR;
							data_out_ff <= tx_par_ff;
						end else begin
							tx_st_ff    <= TX_STOP;
							data_out_ff <= 1'b1;
						end
					end else begin
						tx_cnt_ff   <= tx_cnt_ff + 4'h1;
						data_out_ff <= tx_sh_ff[0];
						tx_sh_ff    <= {1'b0, tx_sh_ff[7:1]};
					end
				end
			end
			TX_PAR: begin
				if (tx_bit_end) begin
					tx_st_ff    <= TX_STOP;
					data_out_ff <= 1'b1;
				end
			end
			TX_STOP: begin
				if (tx_bit_end) begin
					if (amc_ff.stop2 && !tx_stop_ff) begin
						tx_stop_ff <= 1'b1;
					end else begin
						tx_st_ff   <= TX_IDLE;
						tx_done_ff <= 1'b1;
					end
				end
			end
			TX_SYNC: begin
				// data changes on the falling clock edge, input is
				// taken on the rising one
				if (tx_half && !tx_ph_ff) begin
					sclk_out_ff <= 1'b0;
					data_out_ff <= cmc_ff.lsb_first ?
						tx_sh_ff[0] : tx_sh_ff[7];
				end else if (tx_half) begin
					sclk_out_ff <= 1'b1;
					tx_cnt_ff   <= tx_cnt_ff + 4'h1;
					if (cmc_ff.lsb_first) begin
						sy_in_ff <= {rxd, sy_in_ff[7:1]};
						tx_sh_ff <= {1'b0, tx_sh_ff[7:1]};
					end else begin
						sy_in_ff <= {sy_in_ff[6:0], rxd};
						tx_sh_ff <= {tx_sh_ff[6:0], 1'b0};
					end
					if (tx_cnt_ff == BITS_8 - 4'h1) begin
						tx_st_ff   <= TX_IDLE;
						tx_done_ff <= 1'b1;
						sy_done_ff <= 1'b1;
					end
				end
			end
			default: tx_st_ff <= TX_IDLE;
			endcase
		end
	end

	// ------------------------------------------------------------
	// asynchronous receiver
	// ------------------------------------------------------------
	// runs beside the transmitter on its own timing, so both
	// directions may be busy together
	assign rx_go  = rx_st_ff == RX_IDLE && amc_ff.rx_en && !sync_on &&
		rxd_prev_ff && !rxd;
	assign rx_smp = rx_half && !rx_ph_ff;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rx_st_ff     <= RX_IDLE;
			rx_sh_ff     <= HOLD_RST;
			rx_cnt_ff    <= 4'h0;
			rx_ph_ff     <= 1'b0;
			rx_par_ff    <= 1'b0;
			rx_fe_ff     <= 1'b0;
			rx_commit_ff <= 1'b0;
		end else if (!amc_ff.rx_en || sync_on) begin
			rx_st_ff     <= RX_IDLE;
			rx_commit_ff <= 1'b0;
		end else begin
			rx_commit_ff <= 1'b0;
			rx_ph_ff     <= rx_ph_ff ^ rx_half;
			unique case (rx_st_ff)
			RX_IDLE: begin
				rx_ph_ff  <= 1'b0;
				rx_cnt_ff <= 4'h0;
				if (rx_go)
					rx_st_ff <= RX_START;
			end
			RX_START: begin
				// a start bit gone high at mid-bit was a glitch
				if (rx_smp)
					rx_st_ff <= rxd ? RX_IDLE : RX_DATA;
			end
			RX_DATA: begin
				if (rx_smp) begin
					rx_sh_ff  <= {rxd, rx_sh_ff[7:1]};
					rx_cnt_ff <= rx_cnt_ff + 4'h1;
					if (rx_cnt_ff == last_bit)
						rx_st_ff <= (amc_ff.parity == PAR_NONE) ?
							RX_STOP : RX_PAR;
				end
			end
			RX_PAR: begin
				if (rx_smp) begin
					rx_par_ff <= rxd;
					rx_st_ff  <= RX_STOP;
				end
			end
			RX_STOP: begin
				// a second stop bit is never looked at
				if (rx_smp) begin
					rx_fe_ff     <= !rxd;
					rx_commit_ff <= 1'b1;
					rx_st_ff     <= RX_IDLE;
				end
			end
			default: rx_st_ff <= RX_IDLE;
			endcase
		end
	end

	// ------------------------------------------------------------
	// receive holding and error status
	// ------------------------------------------------------------
	assign rx_word    = amc_ff.len8 ? rx_sh_ff :
		{1'b0, rx_sh_ff[7:1]};
	assign rx_pe      = amc_ff.parity != PAR_NONE &&
		rx_par_ff != par_of(amc_ff.parity, rx_word);
	// a read in the same cycle frees the holding register first
	assign unread_eff = rx_unread_ff && !rd_data;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			hold_rx_ff   <= HOLD_RST;
			rx_unread_ff <= 1'b0;
			aes_ff       <= CTRL_RST;
			rx_done_ff   <= 1'b0;
			rx_error_ff  <= 1'b0;
		end else begin
			rx_done_ff  <= 1'b0;
			rx_error_ff <= 1'b0;
			if (rx_commit_ff) begin
				// on overrun the unread byte is kept, the new one lost
				aes_ff       <= {5'h00, rx_pe, rx_fe_ff,
					unread_eff};
				rx_unread_ff <= 1'b1;
				rx_done_ff   <= 1'b1;
				rx_error_ff  <= rx_pe || rx_fe_ff || unread_eff;
				if (!unread_eff)
					hold_rx_ff <= rx_word;
			end else if (sy_done_ff) begin
				hold_rx_ff   <= sy_in_ff;
				rx_unread_ff <= 1'b1;
				rx_done_ff   <= 1'b1;
			end else if (rd_data) begin
				rx_unread_ff <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// read port and pin enables
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			sfr_rdata_ff <= CTRL_RST;
		end else if (sfr_req.rd) begin
			if (hit(sfr_req, ADDR_DATA))
				sfr_rdata_ff <= hold_rx_ff;
			else if (hit(sfr_req, ADDR_AMC))
				sfr_rdata_ff <= amc_ff;
			else if (hit(sfr_req, ADDR_AES))
				sfr_rdata_ff <= aes_ff;
			else if (hit(sfr_req, ADDR_RGC))
				sfr_rdata_ff <= rgc_ff;
			else if (hit(sfr_req, ADDR_CMC))
				sfr_rdata_ff <= cmc_ff;
			else
				sfr_rdata_ff <= CTRL_RST;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			data_out_en_n_ff <= 1'b1;
			sclk_out_en_n_ff <= 1'b1;
			tx_queue_full_ff <= 1'b0;
		end else begin
			data_out_en_n_ff <= !(amc_ff.tx_en || sync_on);
			sclk_out_en_n_ff <= !sync_on;
			tx_queue_full_ff <= !q_in_ready;
		end
	end

endmodule

// *** verification/dmsc_channel_monitor.sv ***
// checker: port-level properties of the serial channel
`timescale 1ns/1ns
module dmsc_channel_monitor
	import dmsc_pkg::*;
(
	input logic          clk,
	input logic          rstn,
	input dmsc_sfr_req_t sfr_req,
	input logic [7:0]    sfr_rdata_ff,
	input logic          data_out_ff,
	input logic          data_out_en_n_ff,
	input logic          sclk_out_ff,
	input logic          sclk_out_en_n_ff,
	input logic          tx_done_ff,
	input logic          rx_done_ff,
	input logic          rx_error_ff
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	a_read_hold: assert property (
		!sfr_req.rd |=> $stable(sfr_rdata_ff)) else $error("rdata moved");
	a_unmapped_zero: assert property (
		sfr_req.rd && sfr_req.addr == 16'hff75 |=> sfr_rdata_ff == 8'h00)
		else $error("unmapped read not zero");
	a_error_done: assert property (
		rx_error_ff |-> rx_done_ff) else $error("error without done");
	a_tx_pulse: assert property (
		tx_done_ff |=> !tx_done_ff) else $error("tx done too long");
	a_rx_pulse: assert property (
		rx_done_ff |=> !rx_done_ff) else $error("rx done too long");
	a_stop_high: assert property (
		tx_done_ff && sclk_out_en_n_ff |-> data_out_ff)
		else $error("frame ends low");
	a_clock_idle: assert property (
		sclk_out_en_n_ff |-> sclk_out_ff) else $error("clock not idle");
	a_data_driven: assert property (
		!sclk_out_en_n_ff |-> !data_out_en_n_ff)
		else $error("data pin floats");
	cover property (rx_error_ff);
	cover property (tx_done_ff && !sclk_out_en_n_ff);
	cover property (sfr_req.wr && sfr_req.addr == ADDR_RGC);
endmodule

bind dmsc_channel dmsc_channel_monitor mon (.clk(clk), .rstn(rstn),
	.sfr_req(sfr_req), .sfr_rdata_ff(sfr_rdata_ff),
	.data_out_ff(data_out_ff), .data_out_en_n_ff(data_out_en_n_ff),
	.sclk_out_ff(sclk_out_ff), .sclk_out_en_n_ff(sclk_out_en_n_ff),
	.tx_done_ff(tx_done_ff), .rx_done_ff(rx_done_ff),
	.rx_error_ff(rx_error_ff));

// *** verification/dmsc_peer.sv ***
// behavioural remote serial device on the line side
`timescale 1ns/1ns
module dmsc_peer (
	input  logic        clk,
	input  logic        line_in,
	input  logic        sclk,
	input  logic        loop,
	input  logic [9:0]  bl,
	output logic        line_out,
	output logic [10:0] got,
	output logic [7:0]  sr,
	output logic [9:0]  low_len
);
	logic drv = 1'b1;
	// three-wire: echo the channel's output so every byte comes back
	assign line_out = loop ? line_in : drv;
	initial got = '0;
	always @(posedge sclk)
		if (loop)
			sr <= {sr[6:0], line_in};
	always begin
		@(negedge line_in iff !loop);
		low_len = '0;
		@(negedge clk);
		while (line_in === 1'b0) begin
			low_len = low_len + 10'h1;
			@(negedge clk);
		end
	end
	// mid-bit sampling of ten bits after the start bit
	always begin
		@(negedge line_in iff !loop);
		repeat (bl / 2) @(negedge clk);
		for (int i = 0; i < 10; i++) begin
			repeat (bl) @(negedge clk);
			got[i] = line_in;
		end
	end
	task automatic send(input logic [10:0] f, input int n);
		drv <= 1'b0;
		repeat (bl) @(posedge clk);
		for (int i = 0; i < n; i++) begin
			drv <= f[i];
			repeat (bl) @(posedge clk);
		end
		drv <= 1'b1;
	endtask
endmodule

// *** verification/dmsc_channel_test.sv ***
// self-checking bench for the serial channel
`timescale 1ns/1ns
module dmsc_channel_test
	import dmsc_pkg::*;
;
	logic          clk;
	logic          rstn;
	dmsc_sfr_req_t req;
	logic [7:0]    rdata;
	logic          din;
	logic          rpin;
	logic          dout;
	logic          doen_n;
	logic          sclk;
	logic          sclk_en_n;
	logic          qfull;
	logic          txd;
	logic          rxd;
	logic          receiver_enable;
	logic          loop;
	logic [9:0]    bl;
	logic [10:0]   got;
	logic [7:0]    sr;
	logic [9:0]    low_len;
	int            n_errors;
	int            checked;
	int            n_tx;
	int            base;
	int            cyc;

	dmsc_channel uut (.clk(clk), .rstn(rstn), .sfr_req(req),
		.sfr_rdata_ff(rdata), .data_in_pin(din), .rate_clk_pin(rpin),
		.data_out_ff(dout), .data_out_en_n_ff(doen_n),
		.sclk_out_ff(sclk), .sclk_out_en_n_ff(sclk_en_n),
		.tx_queue_full_ff(qfull), .tx_done_ff(txd), .rx_done_ff(rxd),
		.rx_error_ff(receiver_enable));
	dmsc_peer peer (.clk(clk), .line_in(dout), .sclk(sclk), .loop(loop),
		.bl(bl), .line_out(din), .got(got), .sr(sr), .low_len(low_len));

	always #10 clk = ~clk;
	always @(posedge clk) begin
		// pin held two cycles so the three-flop filter passes it
		if (cyc[0])
			rpin <= ~rpin;
		cyc <= cyc + 1;
		if (txd === 1'b1)
			n_tx <= n_tx + 1;
		if (cyc == 30000) begin
			n_errors++;
			end_of_test();
		end
	end

	task automatic chk(input string nm, input logic [10:0] s,
		input logic [10:0] e);
		checked++;
		if (s !== e) begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		req <= '{1'b1, 1'b0, a, d};
		@(posedge clk);
		req <= '0;
		@(posedge clk);
	endtask
	task automatic rd(input logic [15:0] a, input logic [7:0] e);
		req <= '{1'b0, 1'b1, a, 8'h00};
		@(posedge clk);
		req <= '0;
		@(posedge clk);
		chk($sformatf("reg %h", a), rdata, e);
	endtask
	task automatic txw();
		@(posedge clk iff txd === 1'b1);
		repeat (bl) @(posedge clk);
	endtask
	task automatic send_st(input logic [10:0] f, input int n,
		input logic [7:0] st);
		peer.send(f, n);
		repeat (8) @(posedge clk);
		rd(ADDR_AES, st);
	endtask
	task automatic xfer(input logic [7:0] r, input logic [7:0] e);
		wr(ADDR_RGC, r);
		wr(ADDR_DATA, 8'hc6);
		@(posedge clk iff txd === 1'b1);
		repeat (4) @(posedge clk);
		rd(ADDR_DATA, 8'hc6);
		chk("shift order", sr, e);
	endtask
	task automatic end_of_test();
		if (n_errors == 0 && checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	initial begin
		clk = 1'b0;
		rstn = 1'b0;
		req = '0;
		rpin = 1'b0;
		loop = 1'b0;
		bl = 10'd32;
		n_errors = 0;
		checked = 0;
		n_tx = 0;
		cyc = 0;
		repeat (8) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		for (int i = 0; i < 6; i++)
			rd(16'hff70 + 16'(i), i == 0 ? HOLD_RST : CTRL_RST);
		wr(ADDR_RGC, 8'h50);
		rd(ADDR_RGC, 8'h50);
		wr(ADDR_AES, 8'h07);
		rd(ADDR_AES, 8'h00);
		wr(ADDR_AMC, 8'hc9);
		wr(ADDR_DATA, 8'ha5);
		txw();
		chk("frame", got[9:0], 10'h3a5);
		chk("start bit", low_len, 11'd32);
		fork
			wr(ADDR_DATA, 8'h3c);
			peer.send(11'h1c3, 9);
		join
		txw();
		chk("duplex frame", got[9:0], 10'h33c);
		rd(ADDR_DATA, 8'hc3);
		send_st(11'h05a, 9, 8'h02);
		send_st(11'h111, 9, 8'h01);
		send_st(11'h122, 9, 8'h01);
		rd(ADDR_DATA, 8'h5a);
		send_st(11'h133, 9, 8'h00);
		rd(ADDR_DATA, 8'h33);
		wr(ADDR_AMC, 8'hf9);
		send_st(11'h33c, 10, 8'h04);
		rd(ADDR_DATA, 8'h3c);
		wr(ADDR_AMC, 8'hc1);
		peer.send(11'h0ff, 8);
		repeat (8) @(posedge clk);
		rd(ADDR_DATA, 8'h7f);
		for (int p = 0; p < 4; p++) begin
			wr(ADDR_AMC, {2'b11, 2'(p), 4'h5});
			wr(ADDR_DATA, 8'h83);
			txw();
			chk("parity frame", got[9:0],
				{2'b11, p == 0 || p == 2, 7'h03});
		end
		wr(ADDR_AMC, 8'hc8);
		bl = 10'd128;
		wr(ADDR_DATA, 8'ha5);
		txw();
		chk("ext frame", got[9:0], 10'h3a5);
		chk("ext bit", low_len > 10'd124 && low_len < 10'd132, 1'b1);
		bl = 10'd32;
		wr(ADDR_AMC, 8'hc9);
		base = n_tx;
		for (int i = 0; i < 6; i++) begin
			req <= '{1'b1, 1'b0, ADDR_DATA, 8'(i)};
			@(posedge clk);
		end
		req <= '0;
		@(posedge clk);
		chk("queue full", qfull, 1'b1);
		wait (n_tx == base + 5);
		repeat (400) @(posedge clk);
		chk("frames sent", 11'(n_tx - base), 11'd5);
		wr(ADDR_AMC, 8'h00);
		wr(ADDR_CMC, 8'h82);
		loop <= 1'b1;
		@(posedge clk);
		chk("clock pin", sclk_en_n, 1'b0);
		chk("data pin", doen_n, 1'b0);
		xfer(8'h50, 8'hc6);
		wr(ADDR_CMC, 8'h86);
		xfer(8'h8f, 8'h63);
		end_of_test();
	end
endmodule
